// File: src/lcx_pkg.sv
package lcx_pkg;

	// ----------------------------------------
	// Register bus map
	// ----------------------------------------
	localparam logic [7:0]  REG_CTRL       = 8'h00;
	localparam logic [7:0]  REG_STATUS     = 8'h04;
	localparam logic [15:0] OSC_DIV_INIT   = 16'h029A;

	// ----------------------------------------
	// Memories and codes
	// ----------------------------------------
	localparam logic [6:0]  DD_LAST        = 7'h7F;
	localparam logic [7:0]  SPACE_CODE     = 8'h20;
	localparam logic [7:0]  CMD_CLEAR      = 8'h01;
	localparam logic [3:0]  FRAME_BITS     = 4'hA;
	localparam logic [1:0]  TGT_DD         = 2'h0;
	localparam logic [1:0]  TGT_CG         = 2'h1;
	localparam logic [1:0]  TGT_SEG        = 2'h2;

	// ----------------------------------------
	// Timing, in ticks of the emulated oscillator
	// ----------------------------------------
	localparam int          OSC_REF_KHZ    = 150;
	localparam int          BLINK_MS       = 384;
	localparam int          BLINK_OSC      = BLINK_MS * OSC_REF_KHZ;
	localparam int          EXEC_US        = 40;
	localparam int          EXEC_OSC       =
		(EXEC_US * OSC_REF_KHZ + 999) / 1000;
	localparam int          FRAME_OSC5     = 1200;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_FILL = 3'b010,
		ST_WAIT = 3'b100
	} lcx_state_t;

endpackage

// File: src/lcx_instr_exec.sv
// What this block does
// - Clear fills text memory with 20h, zeroes pointer and shift, sets increment.
// - Return home zeroes pointer and display shift, text memory untouched.
// - Each data read or write steps the pointer up or down by one.
// - Shift-on-write moves display left on increment, right on decrement.
// - No shift on reads, glyph or icon access, or with shift-on-write off.
// - Display-on bit blanks or shows panel; memory contents kept.
// - Cursor bit draws five dots on line eight at the pointer.
// - Blink alternates blank and pattern every 384 ms at 150 kHz.
// - Display, cursor and blink bits written only with extended page off.
// - Width, mirror and invert bits written only with extended page on.
// - Six-wide cells; user glyph bits 5..0, ROM glyphs with blank right column.
// - Six-wide font runs frames at five sixths of five-wide rate.
// - Mirror reverses every glyph left to right, cell positions kept.
// - Invert toggles the cursor cell every 384 ms, ignoring cursor and blink.
// - While busy, only the busy and pointer read is accepted.
// - Select, direction and eight data bits form each instruction.
// - ROM address is code, a zero, then the line number.
// - Only ROM data bits 4..0 are used.
// - Codes with upper nibble zero take user glyph memory.
// - Extended page gates segment address and extension registers.
//
// The address map and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module lcx_instr_exec #(
	parameter int BLINK_OSC  = lcx_pkg::BLINK_OSC,
	parameter int FRAME_OSC5 = lcx_pkg::FRAME_OSC5,
	parameter int EXEC_OSC   = lcx_pkg::EXEC_OSC
) (
	input  wire logic        REF_CLK,
	input  wire logic        RESETN,
	input  wire logic        SCLK,
	input  wire logic        CSN,
	input  wire logic        SDI,
	output logic             SDO,
	output logic             SDO_OE,
	input  wire logic        WB_CYC,
	input  wire logic        WB_STB,
	input  wire logic        WB_WE,
	input  wire logic [7:0]  WB_ADR,
	input  wire logic [3:0]  WB_SEL,
	input  wire logic [31:0] WB_DAT_I,
	output logic      [31:0] WB_DAT_O,
	output logic             WB_ACK,
	input  wire logic [6:0]  PIX_POS,
	input  wire logic [2:0]  PIX_LINE,
	input  wire logic        PIX_SEG,
	output logic      [5:0]  PIX_ROW,
	output logic      [11:0] GLYPH_ROM_ADDR,
	input  wire logic [7:0]  GLYPH_ROM_DATA,
	output logic      [6:0]  DISP_SHIFT,
	output logic             FONT_SIX_WIDE,
	output logic             FRAME_TICK
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [5:0] rev_bits(input logic [5:0] v,
		input logic six);
		logic [5:0] r;
		r = 6'h00;
		for (int i = 0; i < 6; i++) begin
			r[i] = v[5 - i];
		end
		return six ? r : {1'b0, r[5:1]};
	endfunction

	function automatic logic [5:0] width_mask(input logic six);
		return six ? 6'h3F : 6'h1F;
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	lcx_pkg::lcx_state_t state;
	logic [7:0]  dd [0:127];
	logic [7:0]  cg [0:63];
	logic [7:0]  seg [0:15];
	logic [6:0]  ac;
	logic [6:0]  next_ac;
	logic [1:0]  target;
	logic [6:0]  fill_idx;
	logic [6:0]  disp_shift;
	logic        inc;
	logic        sow;
	logic        disp_on;
	logic        cursor_on;
	logic        blink_on;
	logic        ext;
	logic        fw;
	logic        fr;
	logic        bw;
	logic        busy;
	logic [15:0] osc_div;
	logic [15:0] osc_cnt;
	logic        osc_tick;
	logic [7:0]  wait_cnt;
	logic [19:0] blink_cnt;
	logic        blink_phase;
	logic [19:0] frame_cnt;
	logic [19:0] frame_len;

	assign busy          = (state != lcx_pkg::ST_IDLE);
	assign DISP_SHIFT    = disp_shift;
	assign FONT_SIX_WIDE = fw;

	// ----------------------------------------
	// Serial link input filtering
	// ----------------------------------------
	logic [2:0] sclk_s;
	logic [2:0] csn_s;
	logic [2:0] sdi_s;
	logic       sclk_f;
	logic       csn_f;
	logic       sdi_f;
	logic       sdi_now;
	logic       sclk_rise;
	logic       sclk_fall;

	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			sclk_s <= 3'h0;
			csn_s  <= 3'h7;
			sdi_s  <= 3'h0;
			sclk_f <= 1'b0;
			csn_f  <= 1'b1;
			sdi_f  <= 1'b0;
		end else begin
			sclk_s <= {sclk_s[1:0], SCLK};
			csn_s  <= {csn_s[1:0], CSN};
			sdi_s  <= {sdi_s[1:0], SDI};
			if (sclk_s[1] == sclk_s[2])
				sclk_f <= sclk_s[2];
			if (csn_s[1] == csn_s[2])
				csn_f <= csn_s[2];
			if (sdi_s[1] == sdi_s[2])
				sdi_f <= sdi_s[2];
		end
	end

	assign sdi_now   = (sdi_s[1] == sdi_s[2]) ? sdi_s[2] : sdi_f;
	assign sclk_rise = (sclk_s[1] == sclk_s[2]) && sclk_s[2] && !sclk_f;
	assign sclk_fall = (sclk_s[1] == sclk_s[2]) && !sclk_s[2] && sclk_f;

	// ----------------------------------------
	// Frame assembly and read-back
	// ----------------------------------------
	logic [3:0] bit_cnt;
	logic [9:0] shreg;
	logic       frame_done;
	logic       rd_mode;
	logic [7:0] rd_sh;
	logic [7:0] mem_byte;
	logic       f_rs;
	logic       f_rw;
	logic [7:0] f_dat;

	always_comb begin
		mem_byte = dd[ac];
		if (target == lcx_pkg::TGT_CG)
			mem_byte = cg[ac[5:0]];
		else if (target == lcx_pkg::TGT_SEG)
			mem_byte = seg[ac[3:0]];
	end

	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			bit_cnt    <= 4'h0;
			shreg      <= 10'h000;
			frame_done <= 1'b0;
			rd_mode    <= 1'b0;
			rd_sh      <= 8'h00;
		end else begin
			frame_done <= 1'b0;
			if (csn_f) begin
				bit_cnt <= 4'h0;
				rd_mode <= 1'b0;
			end else if (sclk_rise && bit_cnt != lcx_pkg::FRAME_BITS) begin
				shreg   <= {shreg[8:0], sdi_now};
				bit_cnt <= bit_cnt + 4'h1;
				if (bit_cnt == lcx_pkg::FRAME_BITS - 4'h1)
					frame_done <= 1'b1;
				if (bit_cnt == 4'h1) begin
					rd_mode <= sdi_now;
					rd_sh   <= shreg[0] ? mem_byte : {busy, ac};
				end
			end else if (sclk_fall && rd_mode && bit_cnt > 4'h2) begin
				rd_sh <= {rd_sh[6:0], 1'b0};
			end
		end
	end

	assign SDO    = rd_sh[7];
	assign SDO_OE = rd_mode && !csn_f;
	assign f_rs   = shreg[9];
	assign f_rw   = shreg[8];
	assign f_dat  = shreg[7:0];

	// ----------------------------------------
	// Command acceptance
	// ----------------------------------------
	logic cmd_ok;
	logic ins;
	logic wr_data;
	logic rd_data;
	logic is_clear;
	logic is_home;
	logic is_dctl;

	assign cmd_ok   = frame_done && !busy && !(!f_rs && f_rw);
	assign ins      = cmd_ok && !f_rs && !f_rw;
	assign wr_data  = cmd_ok && f_rs && !f_rw;
	assign rd_data  = cmd_ok && f_rs && f_rw;
	assign is_clear = ins && f_dat == lcx_pkg::CMD_CLEAR;
	assign is_home  = ins && f_dat[7:1] == 7'h01;
	assign is_dctl  = ins && f_dat[7:3] == 5'h01;

	always_comb begin
		next_ac = inc ? ac + 7'h01 : ac - 7'h01;
		if (target == lcx_pkg::TGT_CG)
			next_ac[6] = 1'b0;
		else if (target == lcx_pkg::TGT_SEG)
			next_ac[6:4] = 3'h0;
	end

	// ----------------------------------------
	// Instruction execution
	// ----------------------------------------
	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			state      <= lcx_pkg::ST_IDLE;
			ac         <= 7'h00;
			target     <= lcx_pkg::TGT_DD;
			fill_idx   <= 7'h00;
			disp_shift <= 7'h00;
			inc        <= 1'b1;
			sow        <= 1'b0;
			disp_on    <= 1'b0;
			cursor_on  <= 1'b0;
			blink_on   <= 1'b0;
			ext        <= 1'b0;
			fw         <= 1'b0;
			fr         <= 1'b0;
			bw         <= 1'b0;
			wait_cnt   <= 8'h00;
		end else begin
			unique case (state)
			lcx_pkg::ST_FILL: begin
				fill_idx <= fill_idx + 7'h01;
				if (fill_idx == lcx_pkg::DD_LAST)
					state <= lcx_pkg::ST_WAIT;
			end
			lcx_pkg::ST_WAIT: begin
				if (osc_tick) begin
					wait_cnt <= wait_cnt - 8'h01;
					if (wait_cnt == 8'h01)
						state <= lcx_pkg::ST_IDLE;
				end
			end
			lcx_pkg::ST_IDLE: begin
				if (cmd_ok) begin
					state    <= lcx_pkg::ST_WAIT;
					wait_cnt <= 8'(EXEC_OSC);
				end
				if (wr_data || rd_data)
					ac <= next_ac;
				if (wr_data && sow && target == lcx_pkg::TGT_DD)
					disp_shift <= inc ? disp_shift + 7'h01 :
						disp_shift - 7'h01;
				if (is_clear) begin
					state      <= lcx_pkg::ST_FILL;
					fill_idx   <= 7'h00;
					ac         <= 7'h00;
					target     <= lcx_pkg::TGT_DD;
					disp_shift <= 7'h00;
					inc        <= 1'b1;
				end else if (is_home) begin
					ac         <= 7'h00;
					target     <= lcx_pkg::TGT_DD;
					disp_shift <= 7'h00;
				end else if (ins && f_dat[7:2] == 6'h01) begin
					inc <= f_dat[1];
					sow <= f_dat[0];
				end else if (is_dctl && !ext) begin
					disp_on   <= f_dat[2];
					cursor_on <= f_dat[1];
					blink_on  <= f_dat[0];
				end else if (is_dctl && ext) begin
					fw <= f_dat[2];
					fr <= f_dat[1];
					bw <= f_dat[0];
				end else if (ins && f_dat[7:5] == 3'h1) begin
					ext <= f_dat[2];
				end else if (ins && f_dat[7:6] == 2'h1) begin
					if (!ext) begin
						ac     <= {1'b0, f_dat[5:0]};
						target <= lcx_pkg::TGT_CG;
					end else if (f_dat[5:4] == 2'h0) begin
						ac     <= {3'h0, f_dat[3:0]};
						target <= lcx_pkg::TGT_SEG;
					end
				end else if (ins && f_dat[7] && !ext) begin
					ac     <= f_dat[6:0];
					target <= lcx_pkg::TGT_DD;
				end
			end
			default: state <= lcx_pkg::ST_IDLE;
			endcase
		end
	end

	// Memories have no reset: clear instruction is the only fill
	always_ff @(posedge REF_CLK) begin
		if (state == lcx_pkg::ST_FILL)
			dd[fill_idx] <= lcx_pkg::SPACE_CODE;
		else if (wr_data && target == lcx_pkg::TGT_DD)
			dd[ac] <= f_dat;
		if (wr_data && target == lcx_pkg::TGT_CG)
			cg[ac[5:0]] <= f_dat;
		if (wr_data && target == lcx_pkg::TGT_SEG)
			seg[ac[3:0]] <= f_dat;
	end

	// ----------------------------------------
	// Oscillator emulation, blink and frame
	// ----------------------------------------
	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			osc_cnt  <= 16'h0000;
			osc_tick <= 1'b0;
		end else begin
			osc_tick <= (osc_cnt == 16'h0000);
			if (osc_cnt == 16'h0000)
				osc_cnt <= (osc_div == 16'h0000) ? 16'h0000 :
					osc_div - 16'h0001;
			else
				osc_cnt <= osc_cnt - 16'h0001;
		end
	end

	// Blink period in oscillator ticks, so it scales with osc_div
	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			blink_cnt   <= 20'h00000;
			blink_phase <= 1'b0;
		end else if (osc_tick) begin
			if (blink_cnt == 20'(BLINK_OSC - 1)) begin
				blink_cnt   <= 20'h00000;
				blink_phase <= !blink_phase;
			end else begin
				blink_cnt <= blink_cnt + 20'h00001;
			end
		end
	end

	assign frame_len = fw ? 20'(FRAME_OSC5 * 6 / 5) : 20'(FRAME_OSC5);

	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			frame_cnt  <= 20'h00000;
			FRAME_TICK <= 1'b0;
		end else begin
			FRAME_TICK <= 1'b0;
			if (osc_tick) begin
				if (frame_cnt >= frame_len - 20'h00001) begin
					frame_cnt  <= 20'h00000;
					FRAME_TICK <= 1'b1;
				end else begin
					frame_cnt <= frame_cnt + 20'h00001;
				end
			end
		end
	end

	// ----------------------------------------
	// Pixel row pipeline
	// ----------------------------------------
	logic [7:0] p1_code;
	logic [7:0] p1_user;
	logic [7:0] p1_seg;
	logic [2:0] p1_line;
	logic       p1_is_seg;
	logic       p1_at;
	logic [5:0] raw;
	logic [5:0] row;

	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			p1_code        <= 8'h00;
			p1_user        <= 8'h00;
			p1_seg         <= 8'h00;
			p1_line        <= 3'h0;
			p1_is_seg      <= 1'b0;
			p1_at          <= 1'b0;
			GLYPH_ROM_ADDR <= 12'h000;
		end else begin
			p1_code        <= dd[PIX_POS];
			p1_user        <= cg[{dd[PIX_POS][2:0], PIX_LINE}];
			p1_seg         <= seg[PIX_POS[3:0]];
			p1_line        <= PIX_LINE;
			p1_is_seg      <= PIX_SEG;
			p1_at          <= (PIX_POS == ac) && !PIX_SEG;
			GLYPH_ROM_ADDR <= {dd[PIX_POS], 1'b0, PIX_LINE};
		end
	end

	always_comb begin
		if (p1_is_seg)
			raw = p1_seg[5:0];
		else if (p1_code[7:4] == 4'h0)
			raw = p1_user[5:0];
		else if (fw)
			raw = {GLYPH_ROM_DATA[4:0], 1'b0};
		else
			raw = {1'b0, GLYPH_ROM_DATA[4:0]};
		raw = raw & width_mask(fw);
		row = fr ? rev_bits(raw, fw) : raw;
		if (cursor_on && !bw && p1_at && p1_line == 3'h7)
			row = row | (fw ? 6'h3E : 6'h1F);
		if (blink_on && !bw && p1_at && blink_phase)
			row = 6'h00;
		if (bw && p1_at && blink_phase)
			row = ~row & width_mask(fw);
		if (!disp_on)
			row = 6'h00;
	end

	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN)
			PIX_ROW <= 6'h00;
		else
			PIX_ROW <= row;
	end

	// ----------------------------------------
	// Wishbone slave
	// ----------------------------------------
	logic wb_req;
	logic wb_commit;

	assign wb_req    = WB_CYC && WB_STB && !WB_ACK;
	// Write lands on the edge where the master sees ack
	assign wb_commit = WB_CYC && WB_STB && WB_ACK && WB_WE;

	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			WB_ACK   <= 1'b0;
			WB_DAT_O <= 32'h00000000;
			osc_div  <= lcx_pkg::OSC_DIV_INIT;
		end else begin
			WB_ACK <= wb_req;
			if (wb_commit && WB_ADR == lcx_pkg::REG_CTRL) begin
				if (WB_SEL[0])
					osc_div[7:0] <= WB_DAT_I[7:0];
				if (WB_SEL[1])
					osc_div[15:8] <= WB_DAT_I[15:8];
			end
			if (wb_req && !WB_WE) begin
				if (WB_ADR == lcx_pkg::REG_CTRL)
					WB_DAT_O <= {16'h0000, osc_div};
				else if (WB_ADR == lcx_pkg::REG_STATUS)
					WB_DAT_O <= {5'h00, disp_shift, blink_phase,
						busy, sow, inc, ext, bw, fr, fw, blink_on,
						cursor_on, disp_on, target, ac};
				else
					WB_DAT_O <= 32'h00000000;
			end
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking dc @(posedge REF_CLK); endclocking
	default disable iff (!RESETN);

	chk_clear_fill: assert property (
		is_clear |=> state == lcx_pkg::ST_FILL && ac == 7'h00 && inc)
		else $error("clear did not start fill");
	chk_home_zero: assert property (
		is_home |=> ac == 7'h00 && disp_shift == 7'h00 && busy)
		else $error("return home failed");
	chk_step_dd: assert property (
		(wr_data || rd_data) && target == lcx_pkg::TGT_DD
		|=> ac == ($past(inc) ? $past(ac) + 7'h01 : $past(ac) - 7'h01))
		else $error("pointer step wrong");
	chk_shift_dir: assert property (
		wr_data && sow && target == lcx_pkg::TGT_DD
		|=> disp_shift == ($past(inc) ? $past(disp_shift) + 7'h01 :
			$past(disp_shift) - 7'h01))
		else $error("shift direction wrong");
	chk_no_shift: assert property (
		rd_data || (wr_data && target != lcx_pkg::TGT_DD)
		|=> $stable(disp_shift))
		else $error("shift on forbidden access");
	chk_dctl_gate: assert property (
		is_dctl && ext |=> $stable(disp_on) && $stable(cursor_on))
		else $error("display control written in ext page");
	chk_ext_gate: assert property (
		is_dctl && !ext |=> $stable(fw) && $stable(bw))
		else $error("extension bits written outside ext page");
	chk_busy_reject: assert property (
		frame_done && busy |=> $stable(ac) && $stable(inc) && $stable(ext))
		else $error("instruction taken while busy");
	chk_busy_rise: assert property (
		cmd_ok |=> busy ##0 (busy [*2]))
		else $error("busy not raised");
	chk_panel_off: assert property (
		!disp_on |=> PIX_ROW == 6'h00)
		else $error("row lit while display off");
	chk_blink_pace: assert property (
		$changed(blink_phase) |-> $past(osc_tick))
		else $error("blink toggled off oscillator tick");
	chk_rom_line: assert property (
		1'b1 |=> GLYPH_ROM_ADDR[2:0] == $past(PIX_LINE)
		&& !GLYPH_ROM_ADDR[3])
		else $error("rom address layout wrong");

	cov_clear: cover property (is_clear ##[1:200] state == lcx_pkg::ST_WAIT);
	cov_shift: cover property (wr_data && sow);
	cov_invert: cover property (bw && p1_at && blink_phase);
	cov_reject: cover property (frame_done && busy && !f_rw);

endmodule

`default_nettype wire

// File: tb/lcx_host_model.sv
`timescale 1ns/10ps
`default_nettype none

module lcx_host_model (
	input  wire logic REF_CLK,
	output logic      SCLK,
	output logic      CSN,
	output logic      SDI,
	input  wire logic SDO
);
	// Link clock idles low and stands still between frames
	initial begin
		SCLK = 1'b0;
		CSN = 1'b1;
		SDI = 1'b0;
	end

	task automatic hold(input int n);
		repeat (n) @(posedge REF_CLK);
	endtask

	// ----------------------------------------
	// One frame, 80 ns link period
	// ----------------------------------------
	task automatic xfer(input logic rs, input logic rw,
		input logic [7:0] d, output logic [7:0] q);
		logic [9:0] bits;
		bits = {rs, rw, d};
		q = 8'h00;
		CSN <= 1'b0;
		hold(4);
		for (int i = 9; i >= 0; i--) begin
			SDI <= bits[i];
			hold(4);
			SCLK <= 1'b1;
			hold(4);
			// Sample late in the high phase; the next bit lands at the fall
			if (i < 8)
				q[i] = SDO;
			SCLK <= 1'b0;
		end
		hold(4);
		CSN <= 1'b1;
		// Released data line must not keep its last value
		SDI <= ~bits[0];
		// Gap lets the select filter see the frame end
		hold(8);
	endtask
endmodule

`default_nettype wire

// File: tb/lcx_instr_exec_test.sv
`timescale 1ns/10ps
`default_nettype none

module lcx_instr_exec_test;
	localparam int DIV = 2;
	localparam int BLK = 4;
	localparam int FRM = 10;
	logic        ref_clk = 1'b0;
	logic        resetn  = 1'b0;
	logic        sclk, csn, sdi, sdo, sdo_oe, wb_ack, six, frame_tick;
	logic        wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
	logic [7:0]  wb_adr = 8'h00;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
	logic [6:0]  pix_pos = 7'h00, disp_shift;
	logic [2:0]  pix_line = 3'h0;
	logic        pix_seg  = 1'b0;
	logic [5:0]  pix_row;
	logic [11:0] rom_addr;
	logic [7:0]  rom_data;
	int          n_fail = 0;
	int          tests_run = 0;

	always #5 ref_clk = ~ref_clk;

	// ----------------------------------------
	// Glyph ROM model, junk in unused bits
	// ----------------------------------------
	function automatic logic [4:0] e5(input logic [7:0] c,
		input logic [2:0] l);
		return (c[4:0] ^ {l[1:0], l}) | 5'h01;
	endfunction
	function automatic logic [4:0] rev5(input logic [4:0] a);
		return {a[0], a[1], a[2], a[3], a[4]};
	endfunction
	assign rom_data = {3'b101, e5(rom_addr[11:4], rom_addr[2:0])};

	lcx_host_model lcx_host_model_i (
		.REF_CLK (ref_clk),
		.SCLK    (sclk),
		.CSN     (csn),
		.SDI     (sdi),
		.SDO     (sdo)
	);

	lcx_instr_exec #(
		.BLINK_OSC  (BLK),
		.FRAME_OSC5 (FRM),
		.EXEC_OSC   (6)
	) lcx_instr_exec_i (
		.REF_CLK        (ref_clk),
		.RESETN         (resetn),
		.SCLK           (sclk),
		.CSN            (csn),
		.SDI            (sdi),
		.SDO            (sdo),
		.SDO_OE         (sdo_oe),
		.WB_CYC         (wb_cyc),
		.WB_STB         (wb_stb),
		.WB_WE          (wb_we),
		.WB_ADR         (wb_adr),
		.WB_SEL         (4'hF),
		.WB_DAT_I       (wb_dat_i),
		.WB_DAT_O       (wb_dat_o),
		.WB_ACK         (wb_ack),
		.PIX_POS        (pix_pos),
		.PIX_LINE       (pix_line),
		.PIX_SEG        (pix_seg),
		.PIX_ROW        (pix_row),
		.GLYPH_ROM_ADDR (rom_addr),
		.GLYPH_ROM_DATA (rom_data),
		.DISP_SHIFT     (disp_shift),
		.FONT_SIX_WIDE  (six),
		.FRAME_TICK     (frame_tick)
	);

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic wrap_up;
		if (n_fail == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wb(input logic we, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_dat_i <= d;
		do begin
			@(posedge ref_clk);
		end while (wb_ack !== 1'b1);
		q = wb_dat_o;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic stat(output logic [31:0] s);
		wb(1'b0, lcx_pkg::REG_STATUS, 32'h0, s);
	endtask

	task automatic idle;
		logic [31:0] s;
		int n;
		n = 0;
		do begin
			stat(s);
			n++;
		end while (s[18] !== 1'b0 && n < 400);
		check(s[18], 1'b0);
	endtask

	task automatic send(input logic rs, input logic rw,
		input logic [7:0] d, output logic [7:0] q);
		lcx_host_model_i.xfer(rs, rw, d, q);
		if (!(rs == 1'b0 && rw == 1'b1))
			idle();
	endtask

	task automatic cmd(input logic [7:0] d);
		logic [7:0] q;
		send(1'b0, 1'b0, d, q);
	endtask

	task automatic wr(input logic [7:0] d);
		logic [7:0] q;
		send(1'b1, 1'b0, d, q);
	endtask

	task automatic render(input logic [6:0] p, input logic [2:0] l);
		pix_pos <= p;
		pix_line <= l;
		repeat (4) @(posedge ref_clk);
	endtask

	task automatic boot;
		logic [31:0] s;
		resetn <= 1'b0;
		repeat (5) @(posedge ref_clk);
		resetn <= 1'b1;
		@(posedge ref_clk);
		wb(1'b0, lcx_pkg::REG_CTRL, 32'h0, s);
		check(s[15:0], lcx_pkg::OSC_DIV_INIT);
		wb(1'b1, 8'h08, 32'hFFFF_FFFF, s);
		wb(1'b0, 8'h08, 32'h0, s);
		check(s, 32'h0);
		wb(1'b1, lcx_pkg::REG_CTRL, 32'(DIV), s);
		stat(s);
		check(s[17:16], 2'b01);
	endtask

	task automatic frame_gap(input int exp);
		int n;
		n = 0;
		while (frame_tick !== 1'b1 && n < 2000) begin
			@(posedge ref_clk);
			n++;
		end
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (frame_tick !== 1'b1 && n < 100);
		check(n, exp);
	endtask

	// Cell must show only a or b and flip every gap cycles
	task automatic watch(input logic [4:0] a, input logic [4:0] b);
		logic [4:0] prev;
		int t[$];
		@(posedge ref_clk);
		prev = pix_row[4:0];
		for (int i = 0; i < 60; i++) begin
			@(posedge ref_clk);
			if (pix_row[4:0] !== a && pix_row[4:0] !== b)
				check(pix_row[4:0], a);
			if (pix_row[4:0] !== prev)
				t.push_back(i);
			prev = pix_row[4:0];
		end
		check(t.size() >= 3, 1'b1);
		if (t.size() >= 3)
			check(t[2] - t[1], BLK * DIV);
	endtask

	initial begin
		#500_000;
		n_fail++;
		wrap_up();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		logic [31:0] s;
		logic [7:0]  q;
		logic [7:0]  code [6];
		logic [2:0]  ln;
		void'($urandom(32'h079B4641));
		boot();
		frame_gap(FRM * DIV);
		cmd(8'h24);
		cmd(8'h08);
		cmd(8'h20);
		cmd(8'h0E);
		stat(s);
		check(s[15:9], 7'b0000011);
		cmd(8'h05);
		wr(8'h41);
		check(disp_shift, 7'h7F);
		send(1'b0, 1'b1, 8'h00, q);
		check(q, 8'h7F);
		lcx_host_model_i.xfer(1'b0, 1'b0, lcx_pkg::CMD_CLEAR, q);
		stat(s);
		check(s[18], 1'b1);
		// Lands while the fill still runs, so it must be dropped
		lcx_host_model_i.xfer(1'b1, 1'b0, 8'h41, q);
		idle();
		send(1'b0, 1'b1, 8'h00, q);
		check(q, 8'h00);
		check(disp_shift, 7'h00);
		stat(s);
		check(s[17:16], 2'b11);
		for (int i = 0; i < 4; i++) begin
			ln = 3'($urandom_range(0, 7));
			render(7'($urandom_range(0, 127)), ln);
			check(rom_addr, {lcx_pkg::SPACE_CODE, 1'b0, ln});
		end
		cmd(8'h07);
		for (int i = 0; i < 6; i++) begin
			code[i] = 8'h10 + 8'($urandom_range(0, 239));
			wr(code[i]);
		end
		check(disp_shift, 7'd6);
		send(1'b0, 1'b1, 8'h00, q);
		check(q, 8'h06);
		cmd(8'h02);
		check(disp_shift, 7'h00);
		send(1'b0, 1'b1, 8'h00, q);
		check(q, 8'h00);
		for (int i = 0; i < 6; i++) begin
			ln = 3'($urandom_range(0, 6));
			render(7'(i), ln);
			check(rom_addr, {code[i], 1'b0, ln});
			check(pix_row, {1'b0, e5(code[i], ln)});
		end
		send(1'b1, 1'b1, 8'h00, q);
		check(q, code[0]);
		send(1'b0, 1'b1, 8'h00, q);
		check(q, 8'h01);
		check(disp_shift, 7'h00);
		cmd(8'h0A);
		render(7'd2, 3'd0);
		check(pix_row, 6'h00);
		cmd(8'h0E);
		render(7'd2, 3'd0);
		check(pix_row, {1'b0, e5(code[2], 3'd0)});
		render(7'd1, 3'd7);
		check(pix_row, 6'h1F);
		render(7'd2, 3'd7);
		check(pix_row, {1'b0, e5(code[2], 3'd7)});
		cmd(8'h0D);
		render(7'd1, 3'd0);
		watch(5'h00, e5(code[1], 3'd0));
		cmd(8'h24);
		cmd(8'h09);
		cmd(8'h20);
		stat(s);
		check(s[15:9], 7'b0100101);
		watch(e5(code[1], 3'd0), ~e5(code[1], 3'd0));
		cmd(8'h24);
		cmd(8'h0A);
		cmd(8'h20);
		stat(s);
		check(s[14:12], 3'b010);
		render(7'd2, 3'd3);
		check(pix_row, {1'b0, rev5(e5(code[2], 3'd3))});
		cmd(8'h06);
		cmd(8'h5A);
		wr(8'h13);
		cmd(8'h8A);
		wr(8'h03);
		check(disp_shift, 7'h00);
		render(7'd10, 3'd2);
		check(pix_row, {1'b0, rev5(5'h13)});
		cmd(8'h24);
		cmd(8'h45);
		wr(8'h06);
		send(1'b0, 1'b1, 8'h00, q);
		check(q, 8'h06);
		check(sdo_oe, 1'b0);
		cmd(8'h20);
		pix_seg <= 1'b1;
		render(7'd5, 3'd0);
		check(pix_row, {1'b0, rev5(5'h06)});
		pix_seg <= 1'b0;
		boot();
		cmd(8'h24);
		cmd(8'h0C);
		cmd(8'h20);
		check(six, 1'b1);
		frame_gap(FRM * DIV * 6 / 5);
		cmd(8'h0E);
		cmd(lcx_pkg::CMD_CLEAR);
		wr(code[3]);
		render(7'd0, 3'd1);
		check(pix_row, {e5(code[3], 3'd1), 1'b0});
		wrap_up();
	end
endmodule

`default_nettype wire
